/* File: hdl/mbx_device.sv */
// Shared register block: semaphores, mailboxes and doorbells
//
// Function
// - Two semaphore ports, flag and test bit
// - Flag write copies old flag into writer's test
// - Requester reads test: 1 held, 0 owned
// - Owner releases by writing flag zero
// - Semaphores side-neutral, never block other registers
// - System masters agree first on semaphore user
// - Sixteen byte mailboxes, byte/word/dword system access
// - Mailboxes accessible anytime from both sides
// - Concurrent read sees whole old or new value
// - Two 8-bit doorbells, one per direction
// - System write sets local doorbell ones
// - Local write clears local doorbell ones
// - Doorbell bits are set/reset flops, roles mirrored
// - Each doorbell has own per-bit enable register
// - Enabled doorbells ORed with other sources onto irq
// - Global controls disable irq and report status
// - Local handler reads status before doorbell
// - Separate test bit per side per port
// - Reset zeroes semaphores, mailboxes left undefined
// - Reset clears both doorbells
// - Reset clears both doorbell enables
`timescale 1ns/100ps
`include "mbx_params.svh"
module mbx_device
  import mbx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  mbx_link_if.dev link,
  input wire logic loc_other_irq,
  input wire logic sys_other_irq
);

  logic sys_ack_ff;
  logic loc_ack_ff;
  logic sys_take;
  logic loc_take;
  logic [`MBX_NUM_IDX-1:0] sys_hit;
  logic [`MBX_NUM_IDX-1:0] loc_hit;
  byte_t sys_byte [`MBX_NUM_IDX];
  byte_t mbx_ff [`MBX_NUM_MBX];
  logic [`MBX_NUM_SEM-1:0] sem_flag_ff;
  logic [`MBX_NUM_SEM-1:0] sem_sys_test_ff;
  logic [`MBX_NUM_SEM-1:0] sem_loc_test_ff;
  byte_t ldb_ff;
  byte_t ldb_en_ff;
  byte_t sdb_ff;
  byte_t sdb_en_ff;
  logic loc_gen_en_ff;
  logic sys_gen_en_ff;
  logic local_irq_ff;
  logic system_irq_ff;
  logic ldb_pend;
  logic sdb_pend;
  byte_t lsc_rd;
  byte_t sic_rd;
  logic [31:0] sys_rdata_ff;
  logic [31:0] nxt_sys_rdata;
  byte_t loc_rdata_ff;
  byte_t nxt_loc_rdata;
  byte_t ldb_set;
  byte_t ldb_clr;
  byte_t sdb_set;
  byte_t sdb_clr;

  ////////////////////////////////////////////////////////////////////////
  // Access acceptance: one access per request, answered next cycle
  assign sys_take = link.sys_req & ~sys_ack_ff;
  assign loc_take = link.loc_req & ~loc_ack_ff;

  // Per-byte write strobes; system lanes reach any byte
  generate
    for (genvar gi = 0; gi < `MBX_NUM_IDX; gi++) begin : g_hit
      localparam idx_t IDX = idx_t'(gi);
      assign sys_hit[gi] = sys_take & link.sys_wr & (link.sys_addr == IDX[4:2])
                           & link.sys_be[IDX[1:0]];
      assign sys_byte[gi] = link.sys_wdata[8*(gi%4) +: 8];
      assign loc_hit[gi] = loc_take & link.loc_wr & (link.loc_addr == IDX);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Global status views
  assign ldb_pend = |(ldb_ff & ldb_en_ff);
  assign sdb_pend = |(sdb_ff & sdb_en_ff);

  // Status bits visible to both sides
  always_comb begin
    lsc_rd = `MBX_ZERO_BYTE;
    lsc_rd[`GCTL_EN_BIT] = loc_gen_en_ff;
    lsc_rd[`GCTL_DB_BIT] = ldb_pend;
    lsc_rd[`GCTL_OTHER_BIT] = loc_other_irq;
    lsc_rd[`GCTL_IRQ_BIT] = local_irq_ff;
    sic_rd = `MBX_ZERO_BYTE;
    sic_rd[`GCTL_EN_BIT] = sys_gen_en_ff;
    sic_rd[`GCTL_DB_BIT] = sdb_pend;
    sic_rd[`GCTL_OTHER_BIT] = sys_other_irq;
    sic_rd[`GCTL_IRQ_BIT] = system_irq_ff;
  end

  // Register read view of one byte index for one side
  function automatic byte_t reg_rd(input idx_t idx, input side_t side);
    byte_t v;
    v = `MBX_ZERO_BYTE;
    if (idx >= `MBX_IDX_MBX0) begin
      v = mbx_ff[idx[3:0]];
    end else begin
      case (idx)
        `MBX_IDX_SEM0, `MBX_IDX_SEM1: begin
          v[`SEM_FLAG_BIT] = sem_flag_ff[idx[0]];
          v[`SEM_TEST_BIT] = (side == SIDE_SYS) ? sem_sys_test_ff[idx[0]]
                                                : sem_loc_test_ff[idx[0]];
        end
        `MBX_IDX_LDB_EN: v = ldb_en_ff;
        `MBX_IDX_LDB: v = ldb_ff;
        `MBX_IDX_SDB_EN: v = sdb_en_ff;
        `MBX_IDX_SDB: v = sdb_ff;
        `MBX_IDX_LSC: v = lsc_rd;
        `MBX_IDX_SIC: v = sic_rd;
        default: v = `MBX_ZERO_BYTE;
      endcase
    end
    return v;
  endfunction

  // Read data; registers are sampled before any same-edge write
  always_comb begin
    nxt_sys_rdata = `MBX_ZERO_WORD;
    for (int k = 0; k < 4; k++) begin
      if (link.sys_be[k]) begin
        nxt_sys_rdata[8*k +: 8] = reg_rd(idx_t'({link.sys_addr, 2'(k)}), SIDE_SYS);
      end
    end
    nxt_loc_rdata = reg_rd(link.loc_addr, SIDE_LOC);
  end

  // Answer flops and read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_ack_ff <= 1'b0;
      loc_ack_ff <= 1'b0;
      sys_rdata_ff <= `MBX_ZERO_WORD;
      loc_rdata_ff <= `MBX_ZERO_BYTE;
    end else begin
      sys_ack_ff <= sys_take;
      loc_ack_ff <= loc_take;
      if (sys_take && !link.sys_wr) begin
        sys_rdata_ff <= nxt_sys_rdata;
      end
      if (loc_take && !link.loc_wr) begin
        loc_rdata_ff <= nxt_loc_rdata;
      end
    end
  end

  assign link.sys_ack = sys_ack_ff;
  assign link.loc_ack = loc_ack_ff;
  assign link.sys_rdata = sys_rdata_ff;
  assign link.loc_rdata = loc_rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Semaphore ports, identical and tied to neither side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sem_flag_ff <= '0;
      sem_sys_test_ff <= '0;
      sem_loc_test_ff <= '0;
    end else begin
      for (int s = 0; s < `MBX_NUM_SEM; s++) begin
        if (sys_hit[`MBX_IDX_SEM0 + s] && loc_hit[`MBX_IDX_SEM0 + s]) begin
          // System write first, then local write sees its value
          sem_sys_test_ff[s] <= sem_flag_ff[s];
          sem_loc_test_ff[s] <= sys_byte[`MBX_IDX_SEM0 + s][`SEM_FLAG_BIT];
          sem_flag_ff[s] <= link.loc_wdata[`SEM_FLAG_BIT];
        end else if (sys_hit[`MBX_IDX_SEM0 + s]) begin
          sem_sys_test_ff[s] <= sem_flag_ff[s];
          sem_flag_ff[s] <= sys_byte[`MBX_IDX_SEM0 + s][`SEM_FLAG_BIT];
        end else if (loc_hit[`MBX_IDX_SEM0 + s]) begin
          sem_loc_test_ff[s] <= sem_flag_ff[s];
          sem_flag_ff[s] <= link.loc_wdata[`SEM_FLAG_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mailboxes: no reset, no lock; system wins a same-byte write clash
  always_ff @(posedge clk_sys) begin
    for (int m = 0; m < `MBX_NUM_MBX; m++) begin
      if (sys_hit[`MBX_IDX_MBX0 + m]) begin
        mbx_ff[m] <= sys_byte[`MBX_IDX_MBX0 + m];
      end else if (loc_hit[`MBX_IDX_MBX0 + m]) begin
        mbx_ff[m] <= link.loc_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Doorbell set and clear masks per direction
  assign ldb_set = sys_hit[`MBX_IDX_LDB] ? sys_byte[`MBX_IDX_LDB] : `MBX_ZERO_BYTE;
  assign ldb_clr = loc_hit[`MBX_IDX_LDB] ? link.loc_wdata : `MBX_ZERO_BYTE;
  assign sdb_set = loc_hit[`MBX_IDX_SDB] ? link.loc_wdata : `MBX_ZERO_BYTE;
  assign sdb_clr = sys_hit[`MBX_IDX_SDB] ? sys_byte[`MBX_IDX_SDB] : `MBX_ZERO_BYTE;

  // Sticky doorbell bits; set is applied after clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ldb_ff <= `MBX_ZERO_BYTE;
      sdb_ff <= `MBX_ZERO_BYTE;
    end else begin
      ldb_ff <= (ldb_ff & ~ldb_clr) | ldb_set;
      sdb_ff <= (sdb_ff & ~sdb_clr) | sdb_set;
    end
  end

  // Doorbell enables: local side owns one, system side the other
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ldb_en_ff <= `MBX_ZERO_BYTE;
      sdb_en_ff <= `MBX_ZERO_BYTE;
    end else begin
      if (loc_hit[`MBX_IDX_LDB_EN]) begin
        ldb_en_ff <= link.loc_wdata;
      end
      if (sys_hit[`MBX_IDX_SDB_EN]) begin
        sdb_en_ff <= sys_byte[`MBX_IDX_SDB_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Global interrupt enables, written by the side that owns each
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loc_gen_en_ff <= 1'b0;
      sys_gen_en_ff <= 1'b0;
    end else begin
      if (loc_hit[`MBX_IDX_LSC]) begin
        loc_gen_en_ff <= link.loc_wdata[`GCTL_EN_BIT];
      end
      if (sys_hit[`MBX_IDX_SIC]) begin
        sys_gen_en_ff <= sys_byte[`MBX_IDX_SIC][`GCTL_EN_BIT];
      end
    end
  end

  // Interrupt outputs, registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      local_irq_ff <= 1'b0;
      system_irq_ff <= 1'b0;
    end else begin
      local_irq_ff <= loc_gen_en_ff & (ldb_pend | loc_other_irq);
      system_irq_ff <= sys_gen_en_ff & (sdb_pend | sys_other_irq);
    end
  end

  assign link.local_irq_out = local_irq_ff;
  assign link.system_irq_out = system_irq_ff;

endmodule // mbx_device

/* File: hdl/mbx_host_end.sv */
// Requester end: Avalon-MM slave that drives the system and local ports
`timescale 1ns/100ps
`include "mbx_params.svh"
module mbx_host_end
  import mbx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  mbx_link_if.host link,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  host_state_t state_ff;
  logic req_ff;
  side_t side_ff;
  logic wr_ff;
  logic [4:0] addr_ff;
  logic [3:0] be_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic [1:0] space;
  logic av_req;
  logic link_ack;

  assign space = avs_address[6:5];
  assign av_req = avs_read | avs_write;
  assign link_ack = (side_ff == SIDE_SYS) ? link.sys_ack : link.loc_ack;

  // One Avalon master acts for both the system side and the local side
  assign avs_waitrequest = av_req & (state_ff != H_DONE);
  assign avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Port drive, from captured request
  assign link.sys_req = req_ff & (side_ff == SIDE_SYS);
  assign link.loc_req = req_ff & (side_ff == SIDE_LOC);
  assign link.sys_wr = wr_ff;
  assign link.loc_wr = wr_ff;
  assign link.sys_addr = addr_ff[2:0];
  assign link.loc_addr = addr_ff;
  assign link.sys_be = be_ff;
  assign link.sys_wdata = wdata_ff;
  assign link.loc_wdata = wdata_ff[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= H_IDLE;
      req_ff <= 1'b0;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (av_req && (space == `AV_SPACE_SYS || space == `AV_SPACE_LOC)) begin
            state_ff <= H_WAIT;
            req_ff <= 1'b1;
          end else if (av_req) begin
            state_ff <= H_DONE;
          end
        end
        H_WAIT: begin
          if (link_ack) begin
            state_ff <= H_DONE;
            req_ff <= 1'b0;
          end
        end
        H_DONE: state_ff <= H_IDLE;
        default: begin
          state_ff <= H_IDLE;
          req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Capture of the request fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      side_ff <= SIDE_SYS;
      wr_ff <= 1'b0;
      addr_ff <= 5'h00;
      be_ff <= 4'h0;
      wdata_ff <= `MBX_ZERO_WORD;
    end else if (state_ff == H_IDLE && av_req) begin
      side_ff <= (space == `AV_SPACE_LOC) ? SIDE_LOC : SIDE_SYS;
      wr_ff <= avs_write;
      addr_ff <= avs_address[4:0];
      be_ff <= avs_byteenable;
      wdata_ff <= avs_writedata;
    end
  end

  // Read data: port answer or own status, which software polls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `MBX_ZERO_WORD;
    end else if (state_ff == H_WAIT && link_ack && !wr_ff) begin
      rdata_ff <= (side_ff == SIDE_SYS) ? link.sys_rdata : {24'h000000, link.loc_rdata};
    end else if (state_ff == H_IDLE && avs_read) begin
      rdata_ff <= `MBX_ZERO_WORD;
      if (space == `AV_SPACE_STAT) begin
        rdata_ff[`AV_STAT_SYS_IRQ_BIT] <= link.system_irq_out;
        rdata_ff[`AV_STAT_LOC_IRQ_BIT] <= link.local_irq_out;
      end
    end
  end

endmodule // mbx_host_end

/* File: hdl/mbx_link_if.sv */
// Link between the shared register block and its two requesters
`timescale 1ns/100ps
interface mbx_link_if;
  // System side: 32-bit word port with byte enables
  logic sys_req;
  logic sys_wr;
  logic [2:0] sys_addr;
  logic [3:0] sys_be;
  logic [31:0] sys_wdata;
  logic [31:0] sys_rdata;
  logic sys_ack;
  // Local side: 8-bit byte port
  logic loc_req;
  logic loc_wr;
  logic [4:0] loc_addr;
  logic [7:0] loc_wdata;
  logic [7:0] loc_rdata;
  logic loc_ack;
  // Interrupt outputs of the block
  logic local_irq_out;
  logic system_irq_out;

  modport dev (
    input sys_req, sys_wr, sys_addr, sys_be, sys_wdata,
    output sys_rdata, sys_ack,
    input loc_req, loc_wr, loc_addr, loc_wdata,
    output loc_rdata, loc_ack,
    output local_irq_out, system_irq_out
  );

  modport host (
    output sys_req, sys_wr, sys_addr, sys_be, sys_wdata,
    input sys_rdata, sys_ack,
    output loc_req, loc_wr, loc_addr, loc_wdata,
    input loc_rdata, loc_ack,
    input local_irq_out, system_irq_out
  );
endinterface

/* File: hdl/mbx_params.svh */
// Constants for the shared mailbox, doorbell and semaphore block
`ifndef MBX_PARAMS_SVH
`define MBX_PARAMS_SVH

// Register index map, one byte per index
`define MBX_IDX_LSC 5'h08
`define MBX_IDX_SIC 5'h09
`define MBX_IDX_SEM0 5'h0a
`define MBX_IDX_SEM1 5'h0b
`define MBX_IDX_LDB_EN 5'h0c
`define MBX_IDX_LDB 5'h0d
`define MBX_IDX_SDB_EN 5'h0e
`define MBX_IDX_SDB 5'h0f
`define MBX_IDX_MBX0 5'h10
`define MBX_NUM_MBX 16
`define MBX_NUM_SEM 2
`define MBX_NUM_IDX 32

// Semaphore port fields
`define SEM_FLAG_BIT 0
`define SEM_TEST_BIT 1

// Global control/status fields (same layout on both sides)
`define GCTL_EN_BIT 0
`define GCTL_DB_BIT 1
`define GCTL_OTHER_BIT 2
`define GCTL_IRQ_BIT 3

// Reset values
`define MBX_ZERO_BYTE 8'h00
`define MBX_ZERO_WORD 32'h0000_0000

// Controller address spaces, avs_address[6:5]
`define AV_SPACE_SYS 2'h0
`define AV_SPACE_LOC 2'h1
`define AV_SPACE_STAT 2'h2
`define AV_STAT_SYS_IRQ_BIT 0
`define AV_STAT_LOC_IRQ_BIT 1

`endif

/* File: hdl/mbx_pkg.sv */
// Types shared by both ends of the mailbox link
package mbx_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] idx_t;
  typedef enum logic {SIDE_SYS = 1'b0, SIDE_LOC = 1'b1} side_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_DONE = 2'b11
  } host_state_t;
endpackage

/* File: verif/mbx_link_checker.sv */
// Assertions on the link between the shared register block and its requester
`timescale 1ns/100ps
module mbx_link_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sys_req,
  input wire logic sys_wr,
  input wire logic [2:0] sys_addr,
  input wire logic [3:0] sys_be,
  input wire logic [31:0] sys_wdata,
  input wire logic [31:0] sys_rdata,
  input wire logic sys_ack,
  input wire logic loc_req,
  input wire logic loc_wr,
  input wire logic [4:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  input wire logic [7:0] loc_rdata,
  input wire logic loc_ack,
  input wire logic local_irq_out,
  input wire logic system_irq_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic s_take;
  logic l_take;
  logic [1:0] sw;
  logic [1:0] sv;
  logic [1:0] lw;
  logic [1:0] flag_ff;
  logic [1:0] stest_ff;
  logic [1:0] ltest_ff;
  logic [15:0] s_sem;
  logic [7:0] l_sem;
  ////////////////////////////////////////////////////////////////////////
  // Accesses taken and semaphore writes from each side
  assign s_take = sys_req && !sys_ack;
  assign l_take = loc_req && !loc_ack;
  assign sw = {2{s_take && sys_wr && sys_addr == 3'h2}} & sys_be[3:2];
  assign sv = {sys_wdata[24], sys_wdata[16]};
  assign lw = {2{l_take && loc_wr && loc_addr[4:1] == 4'h5}} & {loc_addr[0], !loc_addr[0]};
  assign s_sem = {6'h0, stest_ff[1], flag_ff[1], 6'h0, stest_ff[0], flag_ff[0]};
  assign l_sem = {6'h0, ltest_ff[loc_addr[0]], flag_ff[loc_addr[0]]};
  // Reference semaphores, system write ordered before local write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 2'h0;
      stest_ff <= 2'h0;
      ltest_ff <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (sw[p]) stest_ff[p] <= flag_ff[p];
        if (lw[p]) ltest_ff[p] <= sw[p] ? sv[p] : flag_ff[p];
        if (lw[p]) flag_ff[p] <= loc_wdata[0];
        else if (sw[p]) flag_ff[p] <= sv[p];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_sys_ack_due: assert property (s_take |=> sys_ack)
    else $error("system access not answered next cycle");
  chk_sys_ack_pulse: assert property (sys_ack |=> !sys_ack)
    else $error("system ack longer than one cycle");
  chk_loc_ack_due: assert property (l_take |=> loc_ack)
    else $error("local access not answered next cycle");
  chk_loc_ack_pulse: assert property (loc_ack |=> !loc_ack)
    else $error("local ack longer than one cycle");
  chk_ack_has_cause: assert property (sys_ack |-> $past(sys_req))
    else $error("system ack without request");
  chk_irq_reset_low: assert property ($rose(rst_n) |-> !local_irq_out && !system_irq_out)
    else $error("interrupt active after reset");
  chk_sem_sys_read: assert property (s_take && !sys_wr && sys_addr == 3'h2 && sys_be == 4'hf
    |=> sys_rdata[31:16] == $past(s_sem))
    else $error("system semaphore read mismatch");
  chk_sem_loc_read: assert property (l_take && !loc_wr && loc_addr[4:1] == 4'h5
    |=> loc_rdata == $past(l_sem))
    else $error("local semaphore read mismatch");
  cover property (sw != 2'h0);
  cover property (lw != 2'h0);
  cover property ($rose(local_irq_out));
endmodule // mbx_link_checker

/* File: verif/tb_shared_mailbox_doorbell_semaphore.sv */
// Testbench driving the requester end over Avalon-MM against the register block
`timescale 1ns/100ps
module tb_shared_mailbox_doorbell_semaphore;
  logic clk_sys;
  logic rst_n;
  logic [6:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic loc_other_irq;
  logic sys_other_irq;
  logic [31:0] dpat;
  int n_fail;
  int tests_run;
  mbx_link_if link();
  mbx_device u_mbx_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .loc_other_irq(loc_other_irq), .sys_other_irq(sys_other_irq));
  mbx_host_end u_mbx_host_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  mbx_link_checker u_mbx_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .sys_req(link.sys_req), .sys_wr(link.sys_wr), .sys_addr(link.sys_addr),
    .sys_be(link.sys_be), .sys_wdata(link.sys_wdata), .sys_rdata(link.sys_rdata),
    .sys_ack(link.sys_ack), .loc_req(link.loc_req), .loc_wr(link.loc_wr),
    .loc_addr(link.loc_addr), .loc_wdata(link.loc_wdata), .loc_rdata(link.loc_rdata),
    .loc_ack(link.loc_ack), .local_irq_out(link.local_irq_out),
    .system_irq_out(link.system_irq_out));
  ////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [6:0] sa(input logic [2:0] w);
    return {4'h0, w};
  endfunction
  function automatic logic [6:0] la(input logic [4:0] i);
    return {2'h1, i};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av_op(input logic wr, input logic [6:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 40) begin
      n_fail++;
      $display("[ERR] %0t waitrequest stuck", $time);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    av_op(1'b1, a, d, be, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    av_op(1'b0, a, 32'h0, 4'hf, q);
    chk(q & m, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    avs_address = 7'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    loc_other_irq = 1'b0;
    sys_other_irq = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(sa(3'h2), 32'h0, 32'hffff_ffff);
    rd(sa(3'h3), 32'h0, 32'hffff_ffff);
    rd(la(5'h0e), 32'h0, 32'hff);
    rd(7'h60, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    // Both ports: system takes, local is refused, release, local takes
    for (int p = 0; p < 2; p++) begin
      wr(sa(3'h2), 32'h0101_0000, 4'h4 << p);
      rd(sa(3'h2), 32'h1 << (16 + 8 * p), 32'hff << (16 + 8 * p));
      wr(la(5'h0a + 5'(p)), 32'h1, 4'h1);
      rd(la(5'h0a + 5'(p)), 32'h3, 32'hff);
      rd(sa(3'h2), 32'h1 << (16 + 8 * p), 32'hff << (16 + 8 * p));
      wr(sa(3'h2), 32'h0, 4'h4 << p);
      rd(sa(3'h2), 32'h2 << (16 + 8 * p), 32'hff << (16 + 8 * p));
      wr(la(5'h0a + 5'(p)), 32'h1, 4'h1);
      rd(la(5'h0a + 5'(p)), 32'h1, 32'hff);
      wr(la(5'h0a + 5'(p)), 32'h0, 4'h1);
    end
    $display("test semaphore done");
    // Mailboxes: dwords from system, bytes from local
    dpat = 32'h4342_4140;
    for (int w = 4; w < 8; w++) begin
      wr(sa(3'(w)), dpat, 4'hf);
      dpat += 32'h0404_0404;
    end
    for (int i = 0; i < 16; i++) rd(la(5'h10 + 5'(i)), 32'h40 + 32'(i), 32'hff);
    wr(la(5'h15), 32'ha5, 4'h1);
    rd(sa(3'h5), 32'h4746_a544, 32'hffff_ffff);
    wr(sa(3'h7), 32'h5a00_0000, 4'h8);
    rd(sa(3'h7), 32'h5a4e_4d4c, 32'hffff_ffff);
    $display("test mailbox done");
    // Local doorbell with its enables and global control
    wr(la(5'h0c), 32'h05, 4'h1);
    wr(la(5'h08), 32'h01, 4'h1);
    wr(sa(3'h3), 32'h0000_a000, 4'h2);
    wr(sa(3'h3), 32'h0000_0100, 4'h2);
    rd(la(5'h0d), 32'ha1, 32'hff);
    rd(7'h40, 32'h2, 32'h2);
    wr(la(5'h0d), 32'h01, 4'h1);
    rd(la(5'h0d), 32'ha0, 32'hff);
    rd(7'h40, 32'h0, 32'h2);
    wr(sa(3'h3), 32'h0000_00ff, 4'h1);
    rd(la(5'h0c), 32'h05, 32'hff);
    wr(la(5'h0c), 32'ha0, 4'h1);
    rd(7'h40, 32'h2, 32'h2);
    wr(la(5'h08), 32'h00, 4'h1);
    rd(7'h40, 32'h0, 32'h2);
    wr(la(5'h0d), 32'ha0, 4'h1);
    loc_other_irq <= 1'b1;
    wr(la(5'h08), 32'h01, 4'h1);
    rd(la(5'h08), 32'h0d, 32'hff);
    rd(7'h40, 32'h2, 32'h2);
    loc_other_irq <= 1'b0;
    $display("test local doorbell done");
    // System doorbell, roles reversed
    wr(sa(3'h3), 32'h0003_0000, 4'h4);
    wr(sa(3'h2), 32'h0000_0100, 4'h2);
    wr(la(5'h0f), 32'h12, 4'h1);
    rd(7'h40, 32'h1, 32'h1);
    wr(la(5'h0f), 32'h02, 4'h1);
    wr(sa(3'h3), 32'h0200_0000, 4'h8);
    rd(sa(3'h3), 32'h1000_0000, 32'hff00_0000);
    rd(7'h40, 32'h0, 32'h1);
    sys_other_irq <= 1'b1;
    rd(7'h40, 32'h1, 32'h1);
    sys_other_irq <= 1'b0;
    wr(la(5'h0e), 32'hff, 4'h1);
    rd(sa(3'h3), 32'h0003_0000, 32'h00ff_0000);
    $display("test system doorbell done");
    end_of_test();
  end
endmodule // tb_shared_mailbox_doorbell_semaphore
